// File: hdl/conv_rate_timer.sv
// free-running conversion period timer driven by the programmed rate code
`timescale 1ns/1ps
`default_nettype none
module conv_rate_timer #(
  parameter int unsigned SLOW_CYC = temp_seq_pkg::SLOWEST_PERIOD_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic [3:0] rateCode,
  output logic tick
);
  // the fastest period must still be at least one cycle
  if ((SLOW_CYC >> temp_seq_pkg::RATE_FASTEST) < 1)
  begin : g_chk
    $error("conv_rate_timer: SLOW_CYC too small");
  end

  logic [31:0] count_reg; // cycles since last tick
  logic [31:0] count_next;
  logic tick_next;
  logic [3:0] codeClamp; // codes above the fastest act as the fastest
  logic [31:0] period; // cycles per conversion start

  // next count; disabled timer parks at zero so it ticks on re-enable at once
  always_comb
  begin
    codeClamp = (rateCode > temp_seq_pkg::RATE_FASTEST) ? temp_seq_pkg::RATE_FASTEST : rateCode;
    period = SLOW_CYC >> codeClamp;
    tick_next = 1'b0;
    count_next = count_reg;
    if (!enable)
      count_next = '0;
    else if (count_reg == 32'h0000_0000)
    begin
      tick_next = 1'b1;
      count_next = (period > 32'h1) ? 32'h1 : 32'h0;
    end
    else if (count_reg >= period - 32'h1)
      count_next = '0;
    else
      count_next = count_reg + 32'h1;
  end

  // register the timer
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      tick <= tick_next;
    end
  end
endmodule // conv_rate_timer
`default_nettype wire

// File: hdl/dual_temp_conversion_sequencer.sv
// two-channel temperature conversion sequencer with AXI4-Lite registers
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dual_temp_conversion_sequencer #(
  parameter int unsigned INTEG_CYC = temp_seq_pkg::INTEG_LEGACY_CYC,
  parameter int unsigned SLOW_CYC = temp_seq_pkg::SLOWEST_PERIOD_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic hw_standby_in_b,
  input wire logic [10:0] adcResult,
  output logic adcIntegrate,
  output logic adcLegacy,
  output logic channelRemote,
  output logic biasPnp,
  output logic overtemp_alarm_first_b,
  output logic overtemp_alarm_second_b
);
  localparam int RW = temp_seq_pkg::RESULT_W;
  localparam int DROP = temp_seq_pkg::LEGACY_DROP;
  if (INTEG_CYC < 1 || (INTEG_CYC << temp_seq_pkg::EXT_TIME_SHIFT) < INTEG_CYC)
  begin : g_chk
    $error("dual_temp_conversion_sequencer: bad INTEG_CYC");
  end

  // ---------------- hardware standby pin synchroniser ----------------
  logic [2:0] stbySync_reg; // [0] feeds only [1]
  logic stbyFilt_reg; // accepted pin level, low means standby
  logic stbyFilt_next;
  // accept a change only once the second and third stages agree
  always_comb
  begin
    stbyFilt_next = stbyFilt_reg;
    if (stbySync_reg[1] == stbySync_reg[2])
      stbyFilt_next = stbySync_reg[2];
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stbySync_reg <= 3'h7;
      stbyFilt_reg <= 1'b1;
    end
    else
    begin
      stbySync_reg <= {stbySync_reg[1:0], hw_standby_in_b};
      stbyFilt_reg <= stbyFilt_next;
    end
  end

  // ---------------- register file and bus slave ----------------
  logic [7:0] cfg_reg, cfg_next; // run/stop and sensor type
  logic [3:0] rate_reg, rate_next; // conversion rate code
  logic [7:0] limit1_reg, limit1_next; // remote alarm threshold, whole degrees
  logic [7:0] limit2_reg, limit2_next; // local alarm threshold, whole degrees
  logic [7:0] awAddr_reg, awAddr_next;
  logic awHeld_reg, awHeld_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0] wStrb_reg, wStrb_next;
  logic wHeld_reg, wHeld_next;
  logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next;
  logic doWrite; // both halves held, response slot free
  logic oneShotWr; // one-shot command this cycle
  logic stbySw, stbyHw, busy;
  logic [RW-1:0] localResult_reg, remoteResult_reg;
  temp_seq_pkg::seq_state_e seqState_reg, seqState_next;

  assign stbySw = cfg_reg[temp_seq_pkg::CFG_RUNSTOP_BIT];
  assign stbyHw = !stbyFilt_reg;
  assign busy = (seqState_reg != temp_seq_pkg::SEQ_IDLE);
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid;

  // address and data captured in either order; one write and one read in flight
  always_comb
  begin
    cfg_next = cfg_reg;
    rate_next = rate_reg;
    limit1_next = limit1_reg;
    limit2_next = limit2_reg;
    awAddr_next = awAddr_reg;
    awHeld_next = awHeld_reg;
    wData_next = wData_reg;
    wStrb_next = wStrb_reg;
    wHeld_next = wHeld_reg;
    bvalid_next = bvalid;
    bresp_next = bresp;
    rvalid_next = rvalid;
    rresp_next = rresp;
    rdata_next = rdata;
    oneShotWr = 1'b0;
    // capture halves
    if (awvalid && awready)
    begin
      awAddr_next = awaddr;
      awHeld_next = 1'b1;
    end
    if (wvalid && wready)
    begin
      wData_next = wdata;
      wStrb_next = wstrb;
      wHeld_next = 1'b1;
    end
    // perform the write; only lane 0 carries writable bits
    if (doWrite)
    begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = temp_seq_pkg::RESP_OKAY;
      unique case (awAddr_reg)
        temp_seq_pkg::OFF_CONFIG:
          if (wStrb_reg[0]) cfg_next = wData_reg[7:0];
        temp_seq_pkg::OFF_RATE:
          if (wStrb_reg[0]) rate_next = wData_reg[3:0];
        temp_seq_pkg::OFF_ONESHOT:
          oneShotWr = 1'b1; // any data starts a single shot
        temp_seq_pkg::OFF_LIMIT1:
          if (wStrb_reg[0]) limit1_next = wData_reg[7:0];
        temp_seq_pkg::OFF_LIMIT2:
          if (wStrb_reg[0]) limit2_next = wData_reg[7:0];
        temp_seq_pkg::OFF_STATUS, temp_seq_pkg::OFF_LOCAL, temp_seq_pkg::OFF_REMOTE: ;
        default:
          bresp_next = temp_seq_pkg::RESP_SLVERR; // unmapped
      endcase
    end
    else if (bvalid && bready)
      bvalid_next = 1'b0;
    // reads answer one cycle after the address is taken
    if (arvalid && arready)
    begin
      rvalid_next = 1'b1;
      rresp_next = temp_seq_pkg::RESP_OKAY;
      rdata_next = '0;
      unique case (araddr)
        temp_seq_pkg::OFF_CONFIG: rdata_next[7:0] = cfg_reg;
        temp_seq_pkg::OFF_RATE: rdata_next[3:0] = rate_reg;
        temp_seq_pkg::OFF_ONESHOT: ;
        temp_seq_pkg::OFF_STATUS:
        begin
          rdata_next[temp_seq_pkg::STAT_BUSY_BIT] = busy;
          rdata_next[temp_seq_pkg::STAT_HWSTBY_BIT] = stbyHw;
          rdata_next[temp_seq_pkg::STAT_ALARM2_BIT] = !overtemp_alarm_second_b;
          rdata_next[temp_seq_pkg::STAT_ALARM1_BIT] = !overtemp_alarm_first_b;
        end
        temp_seq_pkg::OFF_LOCAL: rdata_next[RW-1:0] = localResult_reg;
        temp_seq_pkg::OFF_REMOTE: rdata_next[RW-1:0] = remoteResult_reg;
        temp_seq_pkg::OFF_LIMIT1: rdata_next[7:0] = limit1_reg;
        temp_seq_pkg::OFF_LIMIT2: rdata_next[7:0] = limit2_reg;
        default: rresp_next = temp_seq_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid && rready)
      rvalid_next = 1'b0;
    awready_next = !awHeld_next && !bvalid_next;
    wready_next = !wHeld_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  // register the bus and configuration
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_reg <= temp_seq_pkg::CFG_RESET;
      rate_reg <= temp_seq_pkg::RATE_RESET;
      limit1_reg <= temp_seq_pkg::LIMIT_RESET;
      limit2_reg <= temp_seq_pkg::LIMIT_RESET;
      awAddr_reg <= '0;
      awHeld_reg <= 1'b0;
      wData_reg <= '0;
      wStrb_reg <= '0;
      wHeld_reg <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= temp_seq_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= temp_seq_pkg::RESP_OKAY;
      rdata <= '0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      rate_reg <= rate_next;
      limit1_reg <= limit1_next;
      limit2_reg <= limit2_next;
      awAddr_reg <= awAddr_next;
      awHeld_reg <= awHeld_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      wHeld_reg <= wHeld_next;
      awready <= awready_next;
      wready <= wready_next;
      bvalid <= bvalid_next;
      bresp <= bresp_next;
      arready <= arready_next;
      rvalid <= rvalid_next;
      rresp <= rresp_next;
      rdata <= rdata_next;
    end
  end

  // ---------------- conversion sequencer ----------------
  logic rateTick; // start request from the rate timer
  logic pending_reg, pending_next; // free-run start waiting for idle
  logic freeRun;
  conv_rate_timer #(.SLOW_CYC(SLOW_CYC)) u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .enable(freeRun),
    .rateCode(rate_reg),
    .tick(rateTick)
  );
  assign freeRun = !stbySw && !stbyHw;

  logic [31:0] integCnt_reg, integCnt_next; // cycles left in this channel
  logic extMode_reg, extMode_next; // resolution latched at start
  logic oneShotRun_reg, oneShotRun_next;
  logic [RW-1:0] localHold_reg, localHold_next; // local result until remote ends
  logic [RW-1:0] localResult_next, remoteResult_next;
  logic startSeq, abortSeq, seqDone;
  logic [RW-1:0] sample; // converter word at the requested resolution
  logic [31:0] integLoad;

  // one-shot only outside hardware standby; free-run ticks wait while busy
  always_comb
  begin
    startSeq = !busy && !stbyHw && (oneShotWr || (freeRun && pending_reg));
    abortSeq = busy && (stbyHw || (stbySw && !oneShotRun_reg));
    seqDone = (seqState_reg == temp_seq_pkg::SEQ_REMOTE) && (integCnt_reg == 32'h0) && !abortSeq;
    // a new tick beats the clear of the old one
    pending_next = (pending_reg && !startSeq && freeRun) || rateTick;
    extMode_next = extMode_reg;
    oneShotRun_next = oneShotRun_reg;
    if (startSeq)
    begin
      oneShotRun_next = oneShotWr;
      extMode_next = oneShotWr || (rate_reg <= temp_seq_pkg::RATE_EXT_MAX);
    end
    integLoad = startSeq ? ((oneShotWr || (rate_reg <= temp_seq_pkg::RATE_EXT_MAX)) ?
                            (INTEG_CYC << temp_seq_pkg::EXT_TIME_SHIFT) : INTEG_CYC)
                         : (extMode_reg ? (INTEG_CYC << temp_seq_pkg::EXT_TIME_SHIFT) : INTEG_CYC);
    sample = extMode_reg ? adcResult : {adcResult[RW-1:DROP], {DROP{1'b0}}};
    seqState_next = seqState_reg;
    integCnt_next = integCnt_reg;
    localHold_next = localHold_reg;
    localResult_next = localResult_reg;
    remoteResult_next = remoteResult_reg;
    if (abortSeq)
      seqState_next = temp_seq_pkg::SEQ_IDLE; // results untouched
    else
      unique case (seqState_reg)
        temp_seq_pkg::SEQ_IDLE:
          if (startSeq)
          begin
            seqState_next = temp_seq_pkg::SEQ_LOCAL;
            integCnt_next = integLoad - 32'h1;
          end
        temp_seq_pkg::SEQ_LOCAL:
          if (integCnt_reg == 32'h0)
          begin
            localHold_next = sample;
            seqState_next = temp_seq_pkg::SEQ_REMOTE;
            integCnt_next = integLoad - 32'h1;
          end
          else
            integCnt_next = integCnt_reg - 32'h1;
        temp_seq_pkg::SEQ_REMOTE:
          if (integCnt_reg == 32'h0)
          begin
            localResult_next = localHold_reg;
            remoteResult_next = sample;
            seqState_next = temp_seq_pkg::SEQ_IDLE;
          end
          else
            integCnt_next = integCnt_reg - 32'h1;
        default:
          seqState_next = temp_seq_pkg::SEQ_IDLE;
      endcase
  end

  // register the sequencer and its front-end controls
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seqState_reg <= temp_seq_pkg::SEQ_IDLE;
      integCnt_reg <= '0;
      pending_reg <= 1'b0;
      extMode_reg <= 1'b1;
      oneShotRun_reg <= 1'b0;
      localHold_reg <= '0;
      localResult_reg <= '0;
      remoteResult_reg <= '0;
      adcIntegrate <= 1'b0;
      adcLegacy <= 1'b0;
      channelRemote <= 1'b0;
      biasPnp <= 1'b0;
      overtemp_alarm_first_b <= 1'b1;
      overtemp_alarm_second_b <= 1'b1;
    end
    else
    begin
      seqState_reg <= seqState_next;
      integCnt_reg <= integCnt_next;
      pending_reg <= pending_next;
      extMode_reg <= extMode_next;
      oneShotRun_reg <= oneShotRun_next;
      localHold_reg <= localHold_next;
      localResult_reg <= localResult_next;
      remoteResult_reg <= remoteResult_next;
      adcIntegrate <= (seqState_next != temp_seq_pkg::SEQ_IDLE);
      adcLegacy <= !extMode_next;
      channelRemote <= (seqState_next == temp_seq_pkg::SEQ_REMOTE);
      biasPnp <= cfg_reg[temp_seq_pkg::CFG_PNP_BIT];
      // alarms compare whole degrees, each independently
      overtemp_alarm_first_b <= !($signed(remoteResult_reg[RW-1:DROP]) > $signed(limit1_reg));
      overtemp_alarm_second_b <= !($signed(localResult_reg[RW-1:DROP]) > $signed(limit2_reg));
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_start_busy: assert property (startSeq && !abortSeq |=> busy && channelRemote == 1'b0)
    else $error("busy not raised on start");
  a_hold_results: assert property (busy && !seqDone |=> $stable(localResult_reg) && $stable(remoteResult_reg))
    else $error("results moved mid-sequence");
  a_both_update: assert property (seqDone |=> !busy && localResult_reg == $past(localHold_reg) && remoteResult_reg == $past(sample))
    else $error("results not updated together");
  a_abort_standby: assert property (abortSeq |=> !busy && $stable(localResult_reg))
    else $error("standby did not abort");
  a_hw_oneshot: assert property (stbyHw && !busy |=> !busy)
    else $error("conversion started in hardware standby");
  a_legacy_lsb: assert property (seqDone && !extMode_reg |=> remoteResult_reg[DROP-1:0] == '0)
    else $error("legacy result has fraction");
  a_alarm_first: assert property ($signed(remoteResult_reg[RW-1:DROP]) > $signed(limit1_reg) |=> !overtemp_alarm_first_b)
    else $error("first alarm missed");
  a_mux_remote: assert property ($rose(seqState_reg == temp_seq_pkg::SEQ_REMOTE) |-> channelRemote && $past(seqState_reg) == temp_seq_pkg::SEQ_LOCAL)
    else $error("mux order wrong");
  a_sensor_type: assert property (##1 biasPnp == $past(cfg_reg[temp_seq_pkg::CFG_PNP_BIT]))
    else $error("sensor type not applied");
  c_free_run: cover property (seqDone && !oneShotRun_reg);
  c_one_shot: cover property (seqDone && oneShotRun_reg && stbySw);
  c_abort: cover property (abortSeq);
  c_legacy: cover property (seqDone && !extMode_reg);
endmodule // dual_temp_conversion_sequencer
`default_nettype wire

// File: hdl/temp_seq_pkg.sv
// shared constants, register map and state types for the conversion sequencer
package temp_seq_pkg;
  // clock and timing
  localparam int unsigned CLOCK_HZ = 25_000_000;
  localparam int unsigned CYC_PER_MS = CLOCK_HZ / 1000;
  localparam int unsigned INTEG_LEGACY_MS = 60; // per channel, legacy resolution
  localparam int unsigned INTEG_LEGACY_CYC = INTEG_LEGACY_MS * CYC_PER_MS;
  localparam int unsigned EXT_TIME_SHIFT = 1; // extended integration takes twice as long
  localparam int unsigned SLOWEST_PERIOD_MS = 16000; // 0.0625 Hz
  localparam int unsigned SLOWEST_PERIOD_CYC = SLOWEST_PERIOD_MS * CYC_PER_MS;
  // conversion rate codes: period halves per step, 0 = 0.0625 Hz .. 8 = 16 Hz
  localparam logic [3:0] RATE_FASTEST = 4'h8;
  localparam logic [3:0] RATE_EXT_MAX = 4'h6; // 4 Hz, slowest legacy is next code
  localparam logic [3:0] RATE_RESET = 4'h6;
  // register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_RATE = 8'h04;
  localparam logic [7:0] OFF_ONESHOT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_LOCAL = 8'h10;
  localparam logic [7:0] OFF_REMOTE = 8'h14;
  localparam logic [7:0] OFF_LIMIT1 = 8'h18;
  localparam logic [7:0] OFF_LIMIT2 = 8'h1C;
  // field positions
  localparam int CFG_RUNSTOP_BIT = 6;
  localparam int CFG_PNP_BIT = 5;
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_HWSTBY_BIT = 2;
  localparam int STAT_ALARM2_BIT = 1;
  localparam int STAT_ALARM1_BIT = 0;
  // data widths and reset values
  localparam int RESULT_W = 11; // 10 bits + sign, 0.125 C per lsb
  localparam int LEGACY_DROP = 3; // legacy keeps 7 bits + sign, 1 C per lsb
  localparam int CFG_W = 8;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h55;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOCAL, SEQ_REMOTE} seq_state_e;
endpackage

// File: tb/adc_front_model.sv
// behavioural model of the converter front end feeding the sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
  input wire logic clock,
  input wire logic adcIntegrate,
  input wire logic channelRemote,
  input wire logic [10:0] localVal,
  input wire logic [10:0] remoteVal,
  output logic [10:0] adcResult
);
  logic [10:0] junk = 11'h2AA; // toggles every cycle so idle samples are never stable
  // idle word changes each cycle: a sample outside integration shows up as garbage
  always @(posedge clock)
  begin
    junk <= ~junk;
  end
  // word follows the junction the mux selects
  always_comb
  begin
    if (adcIntegrate)
      adcResult = channelRemote ? remoteVal : localVal;
    else
      adcResult = junk;
  end
endmodule // adc_front_model
`default_nettype wire

// File: tb/dual_temp_conversion_sequencer_tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module dual_temp_conversion_sequencer_tb_top;
  localparam int unsigned INTEG = 20; // shortened integration keeps the run short
  localparam logic [7:0] aCfg = temp_seq_pkg::OFF_CONFIG;
  localparam logic [7:0] aStat = temp_seq_pkg::OFF_STATUS;
  localparam logic [7:0] aLoc = temp_seq_pkg::OFF_LOCAL;
  localparam logic [7:0] aRem = temp_seq_pkg::OFF_REMOTE;
  logic clock = 1'b0; // 25 MHz
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1; // always ready: answers taken at once
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, alarm1_b, alarm2_b;
  logic adcIntegrate, adcLegacy, channelRemote, biasPnp, standby_b = 1'b1;
  logic [10:0] localVal = 11'h0, remoteVal = 11'h0, adcResult;
  int failures = 0, checks = 0, lc = 0, rc = 0, seed = 32'h7EAE7C72;
  // clock generator
  always #20 clock = ~clock;
  // integration cycles per channel, counted where outputs are settled
  always @(negedge clock)
  begin
    if (adcIntegrate === 1'b1 && channelRemote === 1'b0) lc++;
    if (adcIntegrate === 1'b1 && channelRemote === 1'b1) rc++;
  end
  dual_temp_conversion_sequencer #(.INTEG_CYC(INTEG), .SLOW_CYC(2560)) dut (.clock(clock),
    .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .hw_standby_in_b(standby_b),
    .adcResult(adcResult), .adcIntegrate(adcIntegrate), .adcLegacy(adcLegacy),
    .channelRemote(channelRemote), .biasPnp(biasPnp), .overtemp_alarm_first_b(alarm1_b),
    .overtemp_alarm_second_b(alarm2_b));
  adc_front_model model (.clock(clock), .adcIntegrate(adcIntegrate),
    .channelRemote(channelRemote), .localVal(localVal), .remoteVal(remoteVal),
    .adcResult(adcResult));
  task automatic give_verdict;
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write one word; entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3; // sentinel: no answer yet
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (n < 50 && r === 2'h3)
    begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) r = bresp;
      n++;
    end
    if (r === 2'h3)
    begin
      failures++;
      give_verdict();
    end
  endtask
  // read one word; entered just after a rising edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    while (n < 50 && r === 2'h3)
    begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
      end
      n++;
    end
    if (r === 2'h3)
    begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, temp_seq_pkg::RESP_OKAY});
  endtask
  // bounded wait for the sequence level on adcIntegrate
  task automatic waitInteg(input logic lvl, input int bound);
    int n;
    n = 0;
    while (adcIntegrate !== lvl && n < bound)
    begin
      @(posedge clock);
      n++;
    end
    // a level reached on the very last poll is still a success
    if (adcIntegrate !== lvl)
    begin
      failures++;
      give_verdict();
    end
  endtask
  // expected result word: legacy drops the three fraction bits
  function automatic logic [31:0] res(input logic [10:0] v, input logic leg);
    return {21'h0, leg ? {v[10:3], 3'h0} : v};
  endfunction
  // alarm compares whole degrees, signed
  function automatic logic alarmOn(input logic [10:0] v, input logic [7:0] lim);
    return $signed(v[10:3]) > $signed(lim);
  endfunction
  // hang guard
  initial
  begin
    repeat (100000) @(posedge clock);
    failures++;
    give_verdict();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h18, 8'h1C, 8'h10, 8'h14};
    logic [31:0] rv[6] = '{32'h0, 32'h6, 32'h55, 32'h55, 32'h0, 32'h0};
    logic [10:0] oldL, oldR;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    // reset values; results still zero while the first sequence runs
    for (int i = 0; i < 6; i++) rdChk(ra[i], rv[i]);
    rd(8'h20, d, r);
    chk({30'h0, r}, {30'h0, temp_seq_pkg::RESP_SLVERR});
    chk(d, 32'h0);
    wr(8'h20, 32'h1, r);
    chk({30'h0, r}, {30'h0, temp_seq_pkg::RESP_SLVERR});
    // software standby in mid-sequence aborts, results untouched
    waitInteg(1'b1, 200);
    repeat (20) @(posedge clock);
    wr(aCfg, 32'h40, r);
    repeat (4) @(posedge clock);
    chk({31'h0, adcIntegrate}, 32'h0);
    rdChk(aLoc, 32'h0);
    wr(aCfg, 32'h60, r);
    repeat (2) @(posedge clock);
    chk({31'h0, biasPnp}, 32'h1);
    wr(aCfg, 32'h40, r);
    repeat (2) @(posedge clock);
    chk({31'h0, biasPnp}, 32'h0);
    wr(temp_seq_pkg::OFF_LIMIT1, 32'h10, r);
    wr(temp_seq_pkg::OFF_LIMIT2, 32'h10, r);
    oldL = 11'h0;
    oldR = 11'h0;
    // one-shots in software standby; first pair sits on the alarm edge
    for (int i = 0; i < 4; i++)
    begin
      localVal <= (i == 0) ? 11'h088 : 11'($random(seed));
      remoteVal <= (i == 0) ? 11'h081 : 11'($random(seed));
      lc = 0;
      rc = 0;
      wr(temp_seq_pkg::OFF_ONESHOT, 32'h1, r);
      repeat (2) @(posedge clock);
      chk({31'h0, adcIntegrate}, 32'h1);
      chk({31'h0, adcLegacy}, 32'h0);
      rd(aStat, d, r);
      chk({31'h0, d[7]}, 32'h1);
      rdChk(aLoc, res(oldL, 1'b0));
      rdChk(aRem, res(oldR, 1'b0));
      waitInteg(1'b0, 400);
      chk(lc, 2 * INTEG);
      chk(rc, 2 * INTEG);
      rdChk(aLoc, res(localVal, 1'b0));
      rdChk(aRem, res(remoteVal, 1'b0));
      rd(aStat, d, r);
      chk({31'h0, d[7]}, 32'h0);
      chk({31'h0, d[0]}, {31'h0, alarmOn(remoteVal, 8'h10)});
      chk({31'h0, d[1]}, {31'h0, alarmOn(localVal, 8'h10)});
      chk({31'h0, alarm1_b}, {31'h0, ~alarmOn(remoteVal, 8'h10)});
      chk({31'h0, alarm2_b}, {31'h0, ~alarmOn(localVal, 8'h10)});
      oldL = localVal;
      oldR = remoteVal;
    end
    // rate codes 0 to 8 in free-run: resolution and integration length
    localVal <= 11'h7FF;
    remoteVal <= 11'h3FF;
    wr(aCfg, 32'h0, r);
    for (int c = 0; c < 9; c++)
    begin
      wr(temp_seq_pkg::OFF_RATE, 32'(c), r);
      waitInteg(1'b0, 400);
      lc = 0;
      rc = 0;
      waitInteg(1'b1, 3000);
      waitInteg(1'b0, 400);
      chk({31'h0, adcLegacy}, {31'h0, c > 6});
      chk(lc, (c > 6) ? INTEG : 2 * INTEG);
      chk(rc, (c > 6) ? INTEG : 2 * INTEG);
    end
    rdChk(aLoc, res(localVal, 1'b1));
    rdChk(aRem, res(remoteVal, 1'b1));
    // hardware standby aborts and blocks one-shot
    waitInteg(1'b1, 100);
    repeat (10) @(posedge clock);
    standby_b <= 1'b0;
    localVal <= 11'h123;
    repeat (10) @(posedge clock);
    chk({31'h0, adcIntegrate}, 32'h0);
    rdChk(aLoc, 32'h7F8);
    rd(aStat, d, r);
    chk({31'h0, d[2]}, 32'h1);
    wr(temp_seq_pkg::OFF_ONESHOT, 32'h1, r);
    repeat (4) @(posedge clock);
    chk({31'h0, adcIntegrate}, 32'h0);
    standby_b <= 1'b1;
    waitInteg(1'b1, 100);
    give_verdict();
  end
endmodule // dual_temp_conversion_sequencer_tb_top
`default_nettype wire
